// ---- ppc_config_regs.sv ----
// Configuration bank and runtime mode decode for the printer port unit.
// Assumes one 50 MHz clock, synchronous active high reset, and strobes of one cycle.
//
// Summary of operation
// R1 - The runtime mode control register at base plus 402h holds the runtime mode.
// R2 - Selected mode picks decoded runtime registers and base address bits matched.
// R3 - Registers at 403h, 404h, 405h work only in extended ECP mode.
// R4 - A second group of four registers, reached by index, only in extended ECP.
// R5 - Base high bits 7-3 read zero and ignore writes.
// R6 - Software keeps base high bit 2 at zero.
// R7 - Base low bits 1-0 read zero and ignore writes.
// R8 - Software keeps base low bit 2 zero for EPP in ECP or extended registers.
// R9 - Base high resets to 02h and base low to 78h.
// R10 - Interrupt type: bits 7-2 read-only, bit 1 read/write, reset 02h.
// R11 - Interrupt type bit 0 reads 1 in extended mode, otherwise 0.
// R12 - Index 75h reads 04h always, no second DMA channel.
// R13 - Standard mode field writes show as matching code in modified register.
// R14 - Mode 000 drives data lines out; 001 lets software pick direction.
// R15 - Modes 010, 011, 100 select EPP 1.7, EPP 1.9, ECP without EPP.
// R16 - Standard configuration register resets to F2h.
// R17 - Index 70h resets to 07h, index 74h resets to 04h.
// R18 - Activate register at 30h, read/write, resets to 00h.
// R19 - Extended access bit 0 ignores 403h-405h; 1 makes them accessible.
// R20 - Active with power bit 0 stops clock, ECP and EPP time-out; registers kept.
// R21 - Mode 111 is ECP with EPP selectable as runtime mode 100.
// R22 - Modified register resets to 07h and uses codes 0001,0010,0100,1000,0111.
// R23 - One shared mode state seen through both configuration registers.
//
// Chosen here: the address-and-strobe port.
`default_nettype none
module ppc_config_regs (
    input  wire logic                     clock,
    input  wire logic                     srst,
    input  wire ppc_pkg::ppc_cfg_req_type cfg_req,
    output var  logic [7:0]               cfg_rdata,
    input  wire ppc_pkg::ppc_io_req_type  io_req,
    output var  logic [7:0]               io_rdata,
    output var  logic                     io_hit,
    output var  ppc_pkg::ppc_port_ctl_type port_ctl
);
    import ppc_pkg::*;

    logic [7:0]  device_activate;
    logic [2:0]  base_high;
    logic [7:0]  base_low;
    logic [7:0]  irq_number_wake_enable;
    logic        irq_type_rw;
    logic [7:0]  dma_channel_select;
    logic [2:0]  mode_sel;
    logic        ext_access;
    logic        power_mode;
    logic        float_ctl;
    logic [7:0]  port_control;
    logic [7:0]  runtime_mode_control_register;
    logic [7:0]  ext_plain;
    logic [7:0]  ext_index;
    logic [7:0]  second_regs [SECOND_COUNT];
    logic        active;
    logic        ecp_mode;
    logic        epp_mode;
    logic        extended_ecp;
    logic        ext_open;
    logic [15:0] base_full;
    logic [15:0] base_match;
    logic [15:0] offset;
    logic        low_hit;
    logic        high_hit;
    logic        io_sel;
    logic [3:0]  mod_code;
    logic [2:0]  next_mode;
    logic        mod_valid;
    logic [7:0]  next_cfg_rdata;
    logic [7:0]  next_io_rdata;
    logic [1:0]  second_sel;
    ppc_port_ctl_type next_port_ctl;

    // Mode class decode from the shared mode state.
    always_comb begin
        ecp_mode = (mode_sel == MODE_ECP) || (mode_sel == MODE_ECP_EPP); // R15 R21
        epp_mode = (mode_sel == MODE_EPP17) || (mode_sel == MODE_EPP19); // R15
    end

    // Extended ECP is an ECP mode with the runtime mode field at its extended value.
    assign active       = device_activate[0];
    assign extended_ecp = ecp_mode && (runtime_mode_control_register[7:MODE_LSB] == ECR_MODE_EXT); // R1 R3
    assign ext_open     = extended_ecp && ext_access; // R3 R19

    // Base address; A2 drops out of matching when the high group is in use.
    assign base_full  = {5'h00, base_high, base_low[7:BASE_LOW_LSB], 2'h0};
    assign base_match = ecp_mode ? (base_full & A2_MASK) : base_full; // R2 R8
    assign offset     = io_req.addr - base_match;
    assign low_hit    = (offset < RT_SPAN);
    assign high_hit   = ecp_mode && (offset >= RT_HI_BASE) && (offset < RT_HI_END); // R2
    assign io_sel     = active && (low_hit || high_hit);
    assign second_sel = ext_index[1:0];

    // Modified code shown for each standard mode value.
    always_comb begin
        case (mode_sel)
            MODE_SPP_COMPAT: mod_code = MOD_SPP_COMPAT; // R13 R22
            MODE_SPP_EXT:    mod_code = MOD_SPP_EXT;
            MODE_EPP19:      mod_code = MOD_EPP19;
            MODE_ECP:        mod_code = MOD_ECP;
            MODE_ECP_EPP:    mod_code = MOD_ECP_EPP;
            default:         mod_code = MOD_NONE;
        endcase
    end

    // Standard mode value for a code written to the modified register.
    always_comb begin
        mod_valid = 1'b1;
        case (cfg_req.wdata[3:0])
            MOD_SPP_COMPAT: next_mode = MODE_SPP_COMPAT; // R22
            MOD_SPP_EXT:    next_mode = MODE_SPP_EXT;
            MOD_EPP19:      next_mode = MODE_EPP19;
            MOD_ECP:        next_mode = MODE_ECP;
            MOD_ECP_EPP:    next_mode = MODE_ECP_EPP;
            default: begin
                next_mode = mode_sel;
                mod_valid = 1'b0;
            end
        endcase
    end

    // Activate register.
    always_ff @(posedge clock) begin
        if (srst) begin
            device_activate <= RST_ACTIVATE; // R18
        end else if (cfg_req.wr && cfg_req.addr == IDX_ACTIVATE) begin
            device_activate <= cfg_req.wdata; // R18
        end
    end

    // Base address registers; read-only high bits are not stored, low bits 1-0 are stored as zero.
    always_ff @(posedge clock) begin
        if (srst) begin
            base_high <= RST_BASE_HIGH[BASE_HIGH_MSB:0]; // R9
            base_low  <= RST_BASE_LOW; // R9
        end else if (cfg_req.wr) begin
            if (cfg_req.addr == IDX_BASE_HIGH) begin
                base_high <= cfg_req.wdata[BASE_HIGH_MSB:0]; // R5 R6
            end
            if (cfg_req.addr == IDX_BASE_LOW) begin
                base_low <= {cfg_req.wdata[7:BASE_LOW_LSB], 2'h0}; // R7
            end
        end
    end

    // Interrupt number, interrupt type and DMA select registers.
    always_ff @(posedge clock) begin
        if (srst) begin
            irq_number_wake_enable <= RST_IRQ_NUM; // R17
            irq_type_rw            <= RST_IRQ_TYPE[IRQ_TYPE_BIT]; // R10
            dma_channel_select     <= RST_DMA_SEL; // R17
        end else if (cfg_req.wr) begin
            if (cfg_req.addr == IDX_IRQ_NUM) begin
                irq_number_wake_enable <= cfg_req.wdata;
            end
            if (cfg_req.addr == IDX_IRQ_TYPE) begin
                irq_type_rw <= cfg_req.wdata[IRQ_TYPE_BIT]; // R10
            end
            if (cfg_req.addr == IDX_DMA_SEL) begin
                dma_channel_select <= cfg_req.wdata;
            end
        end
    end

    // Shared mode state, written through either configuration register.
    always_ff @(posedge clock) begin
        if (srst) begin
            mode_sel <= RST_STD_CFG[7:MODE_LSB]; // R16 R22
        end else if (cfg_req.wr && cfg_req.addr == IDX_STD_CFG) begin
            mode_sel <= cfg_req.wdata[7:MODE_LSB]; // R13 R23
        end else if (cfg_req.wr && cfg_req.addr == IDX_MOD_CFG && mod_valid) begin
            mode_sel <= next_mode; // R13 R23
        end
    end

    // Remaining standard configuration bits.
    always_ff @(posedge clock) begin
        if (srst) begin
            ext_access <= RST_STD_CFG[STD_EXT_BIT]; // R16
            power_mode <= RST_STD_CFG[STD_PWR_BIT];
            float_ctl  <= RST_STD_CFG[STD_FLOAT_BIT];
        end else if (cfg_req.wr && cfg_req.addr == IDX_STD_CFG) begin
            ext_access <= cfg_req.wdata[STD_EXT_BIT]; // R19
            power_mode <= cfg_req.wdata[STD_PWR_BIT]; // R20
            float_ctl  <= cfg_req.wdata[STD_FLOAT_BIT];
        end
    end

    // Configuration read data, one cycle after the read strobe.
    always_comb begin
        next_cfg_rdata = ZERO_BYTE;
        case (cfg_req.addr)
            IDX_ACTIVATE:  next_cfg_rdata = device_activate;
            IDX_BASE_HIGH: next_cfg_rdata = {5'h00, base_high}; // R5
            IDX_BASE_LOW:  next_cfg_rdata = base_low; // R7
            IDX_IRQ_NUM:   next_cfg_rdata = irq_number_wake_enable;
            IDX_IRQ_TYPE:  next_cfg_rdata = {6'h00, irq_type_rw, extended_ecp}; // R10 R11
            IDX_DMA_SEL:   next_cfg_rdata = dma_channel_select;
            IDX_DMA2:      next_cfg_rdata = DMA2_VALUE; // R12
            IDX_STD_CFG: begin
                next_cfg_rdata = {mode_sel, ext_access, 2'h0, power_mode, float_ctl}; // R13 R23
            end
            IDX_MOD_CFG:   next_cfg_rdata = {4'h0, mod_code}; // R13 R23
            default:       next_cfg_rdata = ZERO_BYTE;
        endcase
    end

    // Configuration read data register.
    always_ff @(posedge clock) begin
        if (srst) begin
            cfg_rdata <= ZERO_BYTE;
        end else if (cfg_req.rd) begin
            cfg_rdata <= next_cfg_rdata;
        end else begin
            cfg_rdata <= ZERO_BYTE;
        end
    end

    // Port control register at base plus 2; bit 5 steers data direction.
    always_ff @(posedge clock) begin
        if (srst) begin
            port_control <= RST_RUNTIME;
        end else if (io_req.wr && io_sel && offset == RT_CONTROL) begin
            port_control <= io_req.wdata;
        end
    end

    // Runtime mode control register, decoded only in ECP modes.
    always_ff @(posedge clock) begin
        if (srst) begin
            runtime_mode_control_register <= RST_RUNTIME;
        end else if (io_req.wr && io_sel && high_hit && offset == RT_MODE) begin
            runtime_mode_control_register <= io_req.wdata; // R1 R2
        end
    end

    // Extended registers; writes are dropped unless access is open.
    always_ff @(posedge clock) begin
        if (srst) begin
            ext_plain <= RST_RUNTIME;
            ext_index <= RST_RUNTIME;
        end else if (io_req.wr && io_sel && high_hit && ext_open) begin
            if (offset == RT_EXT_A) begin
                ext_plain <= io_req.wdata; // R3 R19
            end
            if (offset == RT_EXT_IDX) begin
                ext_index <= io_req.wdata; // R4
            end
        end
    end

    // Second-level group, one register per entry behind the index.
    genvar gi;
    generate
        for (gi = 0; gi < SECOND_COUNT; gi++) begin : g_second
            always_ff @(posedge clock) begin
                if (srst) begin
                    second_regs[gi] <= RST_RUNTIME;
                end else if (io_req.wr && io_sel && high_hit && ext_open && offset == RT_EXT_DAT
                             && second_sel == 2'(gi)) begin
                    second_regs[gi] <= io_req.wdata; // R4
                end
            end
        end
    endgenerate

    // Runtime read data for the registers this block holds.
    always_comb begin
        next_io_rdata = ZERO_BYTE;
        if (io_sel) begin
            if (low_hit && offset == RT_CONTROL) begin
                next_io_rdata = port_control;
            end else if (high_hit && offset == RT_MODE) begin
                next_io_rdata = runtime_mode_control_register; // R1
            end else if (high_hit && ext_open && offset == RT_EXT_A) begin
                next_io_rdata = ext_plain; // R3 R19
            end else if (high_hit && ext_open && offset == RT_EXT_IDX) begin
                next_io_rdata = ext_index;
            end else if (high_hit && ext_open && offset == RT_EXT_DAT) begin
                next_io_rdata = second_regs[second_sel]; // R4
            end else begin
                next_io_rdata = ZERO_BYTE;
            end
        end
    end

    // Runtime read answer, one cycle after the read strobe.
    always_ff @(posedge clock) begin
        if (srst) begin
            io_rdata <= ZERO_BYTE;
            io_hit   <= 1'b0;
        end else begin
            io_rdata <= io_req.rd ? next_io_rdata : ZERO_BYTE;
            io_hit   <= io_req.rd && io_sel; // R2
        end
    end

    // Port control outputs derived from mode, activation and power control.
    always_comb begin
        next_port_ctl = '0;
        next_port_ctl.clock_enable = active && power_mode; // R20
        next_port_ctl.ecp_enable   = active && power_mode && ecp_mode; // R20 R15
        next_port_ctl.epp_timeout_enable = active && power_mode && (epp_mode || (mode_sel == MODE_ECP_EPP
            && runtime_mode_control_register[7:MODE_LSB] == ECR_MODE_EPP)); // R20 R21
        next_port_ctl.epp_rev19  = (mode_sel == MODE_EPP19); // R15
        next_port_ctl.pins_float = float_ctl && !active;
        next_port_ctl.irq_level  = extended_ecp; // R11
        if (mode_sel == MODE_SPP_COMPAT) begin
            next_port_ctl.port_data_lines_oe = 1'b1; // R14
        end else begin
            next_port_ctl.port_data_lines_oe = !port_control[DIR_BIT]; // R14
        end
    end

    // Output register for port control.
    always_ff @(posedge clock) begin
        if (srst) begin
            port_ctl <= '0;
        end else begin
            port_ctl <= next_port_ctl;
        end
    end
endmodule : ppc_config_regs
`default_nettype wire

// ---- ppc_config_regs_bench.sv ----
// Self-checking bench for the printer port configuration bank.
// Assumes the bank answers one cycle after each strobe and never stalls.
`default_nettype none
module ppc_config_regs_bench;
    import ppc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic             clock;
    logic             srst;
    ppc_cfg_req_type  cfg_req;
    logic [7:0]       cfg_rdata;
    ppc_io_req_type   io_req;
    logic [7:0]       io_rdata;
    logic             io_hit;
    ppc_port_ctl_type port_ctl;
    int               fail_count = 0;
    int               num_checks = 0;
    localparam logic [7:0] RST_IDX [11] = '{8'h30, 8'h60, 8'h61, 8'h70, 8'h71, 8'h74, 8'h75, 8'hF0, 8'hF8, 8'h31, 8'hF1};
    localparam logic [7:0] RST_VAL [11] = '{8'h00, 8'h02, 8'h78, 8'h07, 8'h02, 8'h04, 8'h04, 8'hF2, 8'h07, 8'h00, 8'h00};
    localparam logic [2:0] STD_CODE [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
    localparam logic [3:0] MOD_CODE [6] = '{4'h8, 4'h1, 4'h0, 4'h2, 4'h4, 4'h7};

    ppc_config_regs DUT (
        .clock     (clock),
        .srst      (srst),
        .cfg_req   (cfg_req),
        .cfg_rdata (cfg_rdata),
        .io_req    (io_req),
        .io_rdata  (io_rdata),
        .io_hit    (io_hit),
        .port_ctl  (port_ctl)
    );

    // Free-running 50 MHz clock.
    always #10 clock = ~clock;

    // Counts a comparison and reports a mismatch at once.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One-cycle configuration write.
    task automatic cfg_write(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clock);
        cfg_req <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        cfg_req.wr <= 1'b0;
    endtask : cfg_write

    // Configuration read; the data stand only in the cycle after the strobe.
    task automatic cfg_read(input logic [7:0] addr, input logic [7:0] exp);
        @(posedge clock);
        cfg_req <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        cfg_req.rd <= 1'b0;
        #1 check(16'(cfg_rdata), 16'(exp));
    endtask : cfg_read

    // One-cycle runtime write.
    task automatic io_write(input logic [15:0] addr, input logic [7:0] data);
        @(posedge clock);
        io_req <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        io_req.wr <= 1'b0;
    endtask : io_write

    // Runtime read checking data and decode hit.
    task automatic io_read(input logic [15:0] addr, input logic [7:0] exp, input logic hit);
        @(posedge clock);
        io_req <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        io_req.rd <= 1'b0;
        #1 check({io_hit, 7'h0, io_rdata}, {hit, 7'h0, exp});
    endtask : io_read

    // Prints the counts and the verdict, then ends the run.
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results

    // Watchdog that cuts a hung run short.
    initial begin
        repeat (20000) @(posedge clock);
        fail_count++;
        results();
    end

    // Main sequence; base is back at 0278h before any runtime access, so runtime offsets are absolute.
    initial begin
        clock = 1'b0;
        srst = 1'b1;
        cfg_req = '0;
        io_req = '0;
        repeat (6) @(posedge clock);
        srst <= 1'b0;
        for (int i = 0; i < 11; i++) cfg_read(RST_IDX[i], RST_VAL[i]);
        $display("reset values done");
        cfg_write(IDX_BASE_HIGH, 8'hFB);
        cfg_read(IDX_BASE_HIGH, 8'h03);
        cfg_write(IDX_BASE_HIGH, 8'h02);
        cfg_write(IDX_BASE_LOW, 8'hFF);
        cfg_read(IDX_BASE_LOW, 8'hFC);
        cfg_write(IDX_BASE_LOW, 8'h78);
        cfg_write(IDX_IRQ_TYPE, 8'hFF);
        cfg_read(IDX_IRQ_TYPE, 8'h02);
        cfg_write(IDX_IRQ_TYPE, 8'h00);
        cfg_read(IDX_IRQ_TYPE, 8'h00);
        cfg_write(IDX_DMA2, 8'h00);
        cfg_read(IDX_DMA2, 8'h04);
        cfg_write(IDX_IRQ_NUM, 8'h5A);
        cfg_read(IDX_IRQ_NUM, 8'h5A);
        cfg_write(IDX_DMA_SEL, 8'h03);
        cfg_read(IDX_DMA_SEL, 8'h03);
        cfg_write(IDX_ACTIVATE, 8'h01);
        cfg_read(IDX_ACTIVATE, 8'h01);
        $display("access kinds done");
        for (int i = 0; i < 6; i++) begin
            cfg_write(IDX_STD_CFG, {STD_CODE[i], 5'h12});
            cfg_read(IDX_MOD_CFG, {4'h0, MOD_CODE[i]});
            check(16'(port_ctl.epp_rev19), 16'(STD_CODE[i] == MODE_EPP19));
        end
        for (int i = 0; i < 6; i++) begin
            if (MOD_CODE[i] != 4'h0) begin
                cfg_write(IDX_MOD_CFG, {4'h0, MOD_CODE[i]});
                cfg_read(IDX_STD_CFG, {STD_CODE[i], 5'h12});
            end
        end
        cfg_write(IDX_MOD_CFG, 8'h03);
        cfg_read(IDX_STD_CFG, 8'hF2);
        // Back-to-back standard write and modified read, with no idle cycle between them.
        cfg_req <= '{addr: IDX_STD_CFG, wdata: 8'h92, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        cfg_req <= '{addr: IDX_MOD_CFG, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        cfg_req <= '0;
        #1 check(16'(cfg_rdata), 16'(MOD_ECP));
        $display("mode codes done");
        io_read(16'h067A, 8'h00, 1'b1);
        io_write(16'h067A, 8'hE0);
        cfg_read(IDX_IRQ_TYPE, 8'h01);
        check(16'(port_ctl.irq_level), 16'h0001);
        io_write(16'h067C, 8'h01);
        io_write(16'h067D, 8'h5A);
        io_read(16'h067D, 8'h5A, 1'b1);
        io_write(16'h067C, 8'h02);
        io_read(16'h067D, 8'h00, 1'b1);
        cfg_write(IDX_STD_CFG, 8'hE2);
        io_read(16'h067D, 8'h00, 1'b1);
        cfg_write(IDX_STD_CFG, 8'hF2);
        io_write(16'h067A, 8'h20);
        io_read(16'h067D, 8'h00, 1'b1);
        cfg_read(IDX_IRQ_TYPE, 8'h00);
        $display("runtime extended done");
        cfg_write(IDX_STD_CFG, 8'h32);
        io_write(16'h027A, 8'h20);
        cfg_read(IDX_MOD_CFG, 8'h01);
        check(16'(port_ctl.port_data_lines_oe), 16'h0000);
        io_write(16'h027A, 8'h00);
        cfg_read(IDX_MOD_CFG, 8'h01);
        check(16'(port_ctl.port_data_lines_oe), 16'h0001);
        cfg_write(IDX_STD_CFG, 8'h12);
        io_write(16'h027A, 8'h20);
        cfg_read(IDX_MOD_CFG, 8'h08);
        check(16'(port_ctl.port_data_lines_oe), 16'h0001);
        io_read(16'h067A, 8'h00, 1'b0);
        cfg_write(IDX_STD_CFG, 8'hF2);
        io_read(16'h067A, 8'h20, 1'b1);
        cfg_write(IDX_STD_CFG, 8'hF0);
        cfg_read(IDX_STD_CFG, 8'hF0);
        check({port_ctl.clock_enable, port_ctl.ecp_enable}, 16'h0000);
        io_read(16'h067A, 8'h20, 1'b1);
        cfg_write(IDX_STD_CFG, 8'hF2);
        cfg_read(IDX_STD_CFG, 8'hF2);
        check(16'(port_ctl.clock_enable), 16'h0001);
        io_write(16'h067A, 8'h80);
        cfg_read(IDX_IRQ_TYPE, 8'h00);
        check({port_ctl.ecp_enable, port_ctl.epp_timeout_enable}, 16'h0003);
        cfg_write(IDX_ACTIVATE, 8'h00);
        io_read(16'h067A, 8'h00, 1'b0);
        cfg_write(IDX_STD_CFG, 8'hF3);
        cfg_read(IDX_STD_CFG, 8'hF3);
        check({port_ctl.clock_enable, port_ctl.pins_float}, 16'h0001);
        $display("port modes done");
        results();
    end
endmodule : ppc_config_regs_bench

bind ppc_config_regs ppc_config_regs_properties u_props (
    .clock     (clock),
    .srst      (srst),
    .cfg_req   (cfg_req),
    .cfg_rdata (cfg_rdata),
    .io_req    (io_req),
    .io_rdata  (io_rdata),
    .io_hit    (io_hit),
    .port_ctl  (port_ctl)
);
`default_nettype wire

// ---- ppc_config_regs_properties.sv ----
// Concurrent checks on the ports of the printer port configuration bank.
// Assumes one clock and the synchronous active high reset of the bank.
`default_nettype none
module ppc_config_regs_properties
    import ppc_pkg::*;
(
    input wire logic                      clock,
    input wire logic                      srst,
    input wire ppc_pkg::ppc_cfg_req_type  cfg_req,
    input wire logic [7:0]                cfg_rdata,
    input wire ppc_pkg::ppc_io_req_type   io_req,
    input wire logic [7:0]                io_rdata,
    input wire logic                      io_hit,
    input wire ppc_pkg::ppc_port_ctl_type port_ctl
);
    timeunit 1ns;
    timeprecision 1ps;

    // All checks share the one clock and are quiet while reset is held.
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    // Fixed and read-only fields of the configuration bank.
    AST_DMA2_FIXED: assert property (cfg_req.rd && cfg_req.addr == IDX_DMA2 |=> cfg_rdata == DMA2_VALUE)
        else $error("second DMA report not fixed");
    AST_BASE_HIGH_ZERO: assert property (cfg_req.rd && cfg_req.addr == IDX_BASE_HIGH |=> cfg_rdata[7:3] == 5'h0)
        else $error("base high upper bits not zero");
    AST_BASE_LOW_ZERO: assert property (cfg_req.rd && cfg_req.addr == IDX_BASE_LOW |=> cfg_rdata[1:0] == 2'h0)
        else $error("base low lower bits not zero");
    AST_IRQ_TYPE_UPPER: assert property (cfg_req.rd && cfg_req.addr == IDX_IRQ_TYPE |=> cfg_rdata[7:2] == 6'h0)
        else $error("interrupt type upper bits not zero");
    AST_MOD_CODE_LEGAL: assert property (cfg_req.rd && cfg_req.addr == IDX_MOD_CFG |=>
        cfg_rdata[7:4] == 4'h0 && cfg_rdata[3:0] inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h7})
        else $error("modified mode code illegal");
    // Port enables that need the running port clock.
    AST_ECP_NEEDS_CLOCK: assert property (port_ctl.ecp_enable |-> port_ctl.clock_enable)
        else $error("ecp enabled with clock stopped");
    AST_TIMEOUT_NEEDS_CLOCK: assert property (port_ctl.epp_timeout_enable |-> port_ctl.clock_enable)
        else $error("timeout enabled with clock stopped");
    // Runtime answers appear only after a runtime read.
    AST_IO_ONLY_ON_READ: assert property (!io_req.rd |=> !io_hit && io_rdata == 8'h00)
        else $error("runtime answer without read");
    // The interrupt level output follows the type bit seen by software.
    AST_IRQ_LEVEL_FOLLOWS: assert property ((cfg_req.rd && cfg_req.addr == IDX_IRQ_TYPE && !io_req.wr) ##1
        (!cfg_req.wr && !io_req.wr) |=> port_ctl.irq_level == $past(cfg_rdata[0]))
        else $error("interrupt level disagrees with type bit");
    // A standard mode write to ECP shows at once in the modified register.
    AST_STD_MODE_SHARED: assert property ((cfg_req.wr && cfg_req.addr == IDX_STD_CFG &&
        cfg_req.wdata[7:5] == MODE_ECP) ##1 (cfg_req.rd && cfg_req.addr == IDX_MOD_CFG) |=> cfg_rdata[3:0] == MOD_ECP)
        else $error("modified register missed mode write");
endmodule : ppc_config_regs_properties
`default_nettype wire

// ---- ppc_pkg.sv ----
// Package for the printer port configuration bank: indices, resets, field positions and mode codes.
// Assumes a single clock domain and one byte-wide configuration port plus one runtime port.
`default_nettype none
package ppc_pkg;
    // Configuration register indices.
    localparam logic [7:0] IDX_ACTIVATE  = 8'h30;
    localparam logic [7:0] IDX_BASE_HIGH = 8'h60;
    localparam logic [7:0] IDX_BASE_LOW  = 8'h61;
    localparam logic [7:0] IDX_IRQ_NUM   = 8'h70;
    localparam logic [7:0] IDX_IRQ_TYPE  = 8'h71;
    localparam logic [7:0] IDX_DMA_SEL   = 8'h74;
    localparam logic [7:0] IDX_DMA2      = 8'h75;
    localparam logic [7:0] IDX_STD_CFG   = 8'hF0;
    localparam logic [7:0] IDX_MOD_CFG   = 8'hF8;
    // Reset values.
    localparam logic [7:0] RST_ACTIVATE  = 8'h00;
    localparam logic [7:0] RST_BASE_HIGH = 8'h02;
    localparam logic [7:0] RST_BASE_LOW  = 8'h78;
    localparam logic [7:0] RST_IRQ_NUM   = 8'h07;
    localparam logic [7:0] RST_IRQ_TYPE  = 8'h02;
    localparam logic [7:0] RST_DMA_SEL   = 8'h04;
    localparam logic [7:0] DMA2_VALUE    = 8'h04;
    localparam logic [7:0] RST_STD_CFG   = 8'hF2;
    localparam logic [7:0] RST_RUNTIME   = 8'h00;
    localparam logic [7:0] ZERO_BYTE     = 8'h00;
    // Field positions in the standard configuration, base address, interrupt type and port control registers.
    localparam int STD_EXT_BIT   = 4;
    localparam int STD_PWR_BIT   = 1;
    localparam int STD_FLOAT_BIT = 0;
    localparam int MODE_LSB      = 5;
    localparam int BASE_HIGH_MSB = 2;
    localparam int BASE_LOW_LSB  = 2;
    localparam int IRQ_TYPE_BIT  = 1;
    localparam int DIR_BIT       = 5;
    // Standard mode field codes.
    localparam logic [2:0] MODE_SPP_COMPAT = 3'h0;
    localparam logic [2:0] MODE_SPP_EXT    = 3'h1;
    localparam logic [2:0] MODE_EPP17      = 3'h2;
    localparam logic [2:0] MODE_EPP19      = 3'h3;
    localparam logic [2:0] MODE_ECP        = 3'h4;
    localparam logic [2:0] MODE_ECP_EPP    = 3'h7;
    // Modified mode field codes.
    localparam logic [3:0] MOD_SPP_EXT    = 4'h1;
    localparam logic [3:0] MOD_EPP19      = 4'h2;
    localparam logic [3:0] MOD_ECP        = 4'h4;
    localparam logic [3:0] MOD_SPP_COMPAT = 4'h8;
    localparam logic [3:0] MOD_ECP_EPP    = 4'h7;
    localparam logic [3:0] MOD_NONE       = 4'h0;
    // Runtime offsets from the port base.
    localparam logic [15:0] RT_CONTROL = 16'h0002;
    localparam logic [15:0] RT_SPAN    = 16'h0008;
    localparam logic [15:0] RT_HI_BASE = 16'h0400;
    localparam logic [15:0] RT_HI_END  = 16'h0408;
    localparam logic [15:0] RT_MODE    = 16'h0402;
    localparam logic [15:0] RT_EXT_A   = 16'h0403;
    localparam logic [15:0] RT_EXT_IDX = 16'h0404;
    localparam logic [15:0] RT_EXT_DAT = 16'h0405;
    localparam logic [15:0] A2_MASK    = 16'hFFFB;
    // Runtime mode field values.
    localparam logic [2:0] ECR_MODE_EPP = 3'h4;
    localparam logic [2:0] ECR_MODE_EXT = 3'h7;
    localparam int SECOND_COUNT = 4;
    // Configuration port request.
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ppc_cfg_req_type;
    // Runtime port request.
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } ppc_io_req_type;
    // Port control outputs.
    typedef struct packed {
        logic port_data_lines_oe;
        logic clock_enable;
        logic ecp_enable;
        logic epp_timeout_enable;
        logic epp_rev19;
        logic pins_float;
        logic irq_level;
    } ppc_port_ctl_type;
endpackage : ppc_pkg
`default_nettype wire
